// >>> inc/tbmu_pkg.sv
// Shared constants for the barrier message unit and its thread-side sender.
package tbmu_pkg;
   localparam int          TBMU_BARRIERS     = 64;
   localparam int          TBMU_THREADS      = 16;
   localparam int          TBMU_TID_W        = 4;
   localparam int          TBMU_SEL_HI       = 30;
   localparam int          TBMU_SEL_LO       = 24;
   localparam int          TBMU_PRED_EN_BIT  = 23;
   localparam int          TBMU_CNT_EN_BIT   = 15;
   localparam int          TBMU_CNT_HI       = 14;
   localparam int          TBMU_CNT_LO       = 8;
   localparam int          TBMU_SFID_HI      = 19;
   localparam int          TBMU_SFID_LO      = 16;
   localparam int          TBMU_SUM_W        = 16;
   localparam logic [2:0]  TBMU_SUBFN_BARRIER = 3'h4;
   localparam logic [2:0]  TBMU_ERR_OK       = 3'h0;
   // Arbitrary shared function identifier value.
   localparam logic [3:0]  TBMU_SFID_DEFAULT = 4'h3;
   localparam logic [6:0]  TBMU_COUNT_RESET  = 7'h00;
endpackage : tbmu_pkg

// >>> inc/tbmu_if.sv
// Message port between requesting threads and the barrier message unit.
`timescale 1ns/1ps
interface tbmu_if;
   import tbmu_pkg::*;
   logic                    req_valid;
   logic                    req_ready;
   logic [TBMU_TID_W-1:0]   req_thread;
   logic [2:0]              gateway_subfunction_code;
   logic                    ack_request_flag;
   logic [31:0]             pay_w2;
   logic [31:0]             pay_w3;
   logic                    wb_valid;
   logic [TBMU_TID_W-1:0]   wb_thread;
   logic [31:0]             wb_dword0;
   logic                    wb_is_sum;
   modport device (input req_valid, req_thread, gateway_subfunction_code, ack_request_flag,
                   pay_w2, pay_w3, output req_ready, wb_valid, wb_thread, wb_dword0, wb_is_sum);
   modport thread (output req_valid, req_thread, gateway_subfunction_code, ack_request_flag,
                   pay_w2, pay_w3, input req_ready, wb_valid, wb_thread, wb_dword0, wb_is_sum);
endinterface : tbmu_if

// >>> logic/tbmu_gateway.sv
// Barrier message unit: counts arrivals per barrier and releases the waiting threads.
`timescale 1ns/1ps
module tbmu_gateway (
   input  wire logic                       i_clk,
   input  wire logic                       i_rst,
   input  wire logic [3:0]                 i_sfid,
   output logic                            o_busy,
   output logic [5:0]                      o_last_done,
   tbmu_if.device                          port
);
   import tbmu_pkg::*;

   typedef enum logic [0:0] {TBMU_IDLE = 1'b0, TBMU_RELEASE = 1'b1} tbmu_state_e;

   logic [6:0]              term_cnt [TBMU_BARRIERS];
   logic [6:0]              arr_cnt  [TBMU_BARRIERS];
   logic [TBMU_SUM_W-1:0]   pred_sum [TBMU_BARRIERS];
   logic [TBMU_THREADS-1:0] waiters  [TBMU_BARRIERS];
   logic [TBMU_THREADS-1:0] ackers   [TBMU_BARRIERS];
   tbmu_state_e             state;
   logic [TBMU_THREADS-1:0] rel_wait;
   logic [TBMU_THREADS-1:0] rel_ack;
   logic [TBMU_SUM_W-1:0]   rel_sum;
   logic                    rel_pred;
   logic [TBMU_TID_W-1:0]   rel_idx;
   logic [5:0]              sel;
   logic                    pred_en;
   logic [6:0]              use_cnt;
   logic [6:0]              next_arr;
   logic [TBMU_SUM_W-1:0]   next_sum;
   logic                    take;
   logic                    done_now;

   function automatic logic [5:0] popcount32(input logic [31:0] v);
      logic [5:0] c;
      c = 6'h00;
      for (int k = 0; k < 32; k++) begin
         c = c + {5'h00, v[k]};
      end
      return c;
   endfunction : popcount32

   // Turns a thread number into its bit in the requester records.
   function automatic logic [TBMU_THREADS-1:0] thread_bit(input logic [TBMU_TID_W-1:0] idx);
      logic [TBMU_THREADS-1:0] b;
      b = '0;
      b[idx] = 1'b1;
      return b;
   endfunction : thread_bit

   // New requests are held off while a completed barrier is being released.
   assign port.req_ready = (state == TBMU_IDLE);
   assign o_busy         = (state != TBMU_IDLE);
   assign take = port.req_valid && port.req_ready
                 && (port.gateway_subfunction_code == TBMU_SUBFN_BARRIER);
   // Only six selector bits index state; values above 63 are a sender error.
   assign sel     = port.pay_w2[TBMU_SEL_LO+5:TBMU_SEL_LO];
   assign pred_en = port.pay_w2[TBMU_PRED_EN_BIT];
   assign use_cnt = port.pay_w2[TBMU_CNT_EN_BIT] ? port.pay_w2[TBMU_CNT_HI:TBMU_CNT_LO]
                                                 : term_cnt[sel];
   assign next_arr = arr_cnt[sel] + 7'h01;
   assign next_sum = pred_en ? pred_sum[sel] + {10'h000, popcount32(port.pay_w3)}
                             : pred_sum[sel];
   assign done_now = take && (next_arr == use_cnt);

   // One entry per barrier. An entry moves only when the selector names it, so each
   // register has a single driver and reset clears every entry at the same edge.
   for (genvar b = 0; b < TBMU_BARRIERS; b++) begin : g_entry
      logic                    hit;
      logic                    fin;
      logic [6:0]              term_q;
      logic [6:0]              arr_q;
      logic [TBMU_SUM_W-1:0]   sum_q;
      logic [TBMU_THREADS-1:0] wait_q;
      logic [TBMU_THREADS-1:0] ack_q;

      assign hit = take && (sel == 6'(b));
      assign fin = hit && done_now;

      always_ff @(posedge i_clk) begin
         if (i_rst) begin
            term_q <= TBMU_COUNT_RESET;
         end else if (hit && port.pay_w2[TBMU_CNT_EN_BIT]) begin
            term_q <= port.pay_w2[TBMU_CNT_HI:TBMU_CNT_LO];
         end
      end

      always_ff @(posedge i_clk) begin
         if (i_rst) begin
            arr_q <= TBMU_COUNT_RESET;
         end else if (fin) begin
            arr_q <= TBMU_COUNT_RESET;
         end else if (hit) begin
            arr_q <= next_arr;
         end
      end

      // The sum restarts with every iteration, so a finished barrier leaves no sum behind.
      always_ff @(posedge i_clk) begin
         if (i_rst) begin
            sum_q <= '0;
         end else if (fin) begin
            sum_q <= '0;
         end else if (hit) begin
            sum_q <= next_sum;
         end
      end

      always_ff @(posedge i_clk) begin
         if (i_rst) begin
            wait_q <= '0;
         end else if (fin) begin
            wait_q <= '0;
         end else if (hit) begin
            wait_q <= wait_q | thread_bit(port.req_thread);
         end
      end

      always_ff @(posedge i_clk) begin
         if (i_rst) begin
            ack_q <= '0;
         end else if (fin) begin
            ack_q <= '0;
         end else if (hit) begin
            ack_q[port.req_thread] <= port.ack_request_flag;
         end
      end

      assign term_cnt[b] = term_q;
      assign arr_cnt[b]  = arr_q;
      assign pred_sum[b] = sum_q;
      assign waiters[b]  = wait_q;
      assign ackers[b]   = ack_q;
   end : g_entry

   // Release walks the recorded threads one per cycle, lowest first.
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state    <= TBMU_IDLE;
         rel_wait <= '0;
         rel_ack  <= '0;
         rel_sum  <= '0;
         rel_pred <= 1'b0;
      end else begin
         case (state)
            TBMU_IDLE: begin
               if (done_now) begin
                  rel_wait <= waiters[sel] | thread_bit(port.req_thread);
                  rel_ack  <= ackers[sel] | (port.ack_request_flag ? thread_bit(port.req_thread)
                                                                  : '0);
                  rel_sum  <= next_sum;
                  rel_pred <= pred_en;
                  state    <= TBMU_RELEASE;
               end
            end
            TBMU_RELEASE: begin
               rel_wait[rel_idx] <= 1'b0;
               if ((rel_wait & ~thread_bit(rel_idx)) == '0) begin
                  state <= TBMU_IDLE;
               end
            end
            default: state <= TBMU_IDLE;
         endcase
      end
   end

   // Last completed selector; it holds until another barrier completes.
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_last_done <= 6'h00;
      end else if ((state == TBMU_IDLE) && done_now) begin
         o_last_done <= sel;
      end
   end

   always_comb begin
      rel_idx = '0;
      for (int t = TBMU_THREADS - 1; t >= 0; t--) begin
         if (rel_wait[t]) begin
            rel_idx = t[TBMU_TID_W-1:0];
         end
      end
   end

   // Writeback of dword 0 only; the other seven dwords are never driven.
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         port.wb_valid  <= 1'b0;
         port.wb_thread <= '0;
      end else begin
         port.wb_valid  <= (state == TBMU_RELEASE) && (rel_pred || rel_ack[rel_idx]);
         port.wb_thread <= rel_idx;
      end
   end

   // The ack word carries nothing per thread, so one word serves every thread of a release.
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         port.wb_dword0 <= 32'h0000_0000;
         port.wb_is_sum <= 1'b0;
      end else begin
         port.wb_is_sum <= rel_pred;
         if (rel_pred) begin
            port.wb_dword0 <= {16'h0000, rel_sum};
         end else begin
            port.wb_dword0 <= {12'h000, i_sfid, 13'h0000, TBMU_ERR_OK};
         end
      end
   end
endmodule : tbmu_gateway

// >>> logic/tbmu_thread.sv
// Thread-side sender: builds barrier messages and collects their writebacks.
`timescale 1ns/1ps
module tbmu_thread (
   input  wire logic                          i_clk,
   input  wire logic                          i_rst,
   input  wire logic                          i_send,
   input  wire logic [tbmu_pkg::TBMU_TID_W-1:0] i_thread,
   input  wire logic [5:0]                    i_selector,
   input  wire logic                          i_pred_en,
   input  wire logic [1:0]                    i_simd_width,
   input  wire logic [31:0]                   i_pred_mask,
   input  wire logic                          i_cnt_en,
   input  wire logic [6:0]                    i_count,
   input  wire logic                          i_ack,
   output logic                               o_sent,
   output logic                               o_wb_valid,
   output logic [tbmu_pkg::TBMU_TID_W-1:0]    o_wb_thread,
   output logic [31:0]                        o_wb_data,
   tbmu_if.thread                             port
);
   import tbmu_pkg::*;

   logic [31:0] width_mask;

   // Width 0 is eight channels, 1 is sixteen, otherwise all thirty-two.
   always_comb begin
      case (i_simd_width)
         2'h0:    width_mask = 32'h0000_00ff;
         2'h1:    width_mask = 32'h0000_ffff;
         default: width_mask = 32'hffff_ffff;
      endcase
   end

   assign o_sent = port.req_valid && port.req_ready;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         port.req_valid                <= 1'b0;
         port.req_thread               <= '0;
         port.gateway_subfunction_code <= TBMU_SUBFN_BARRIER;
         port.ack_request_flag         <= 1'b0;
         port.pay_w2                   <= 32'h0000_0000;
         port.pay_w3                   <= 32'h0000_0000;
      end else if (i_send && !(port.req_valid && !port.req_ready)) begin
         port.req_valid                <= 1'b1;
         port.req_thread               <= i_thread;
         port.gateway_subfunction_code <= TBMU_SUBFN_BARRIER;
         // Acknowledge is dropped on predicated barriers; the sum replaces it.
         port.ack_request_flag         <= i_ack && !i_pred_en;
         port.pay_w2 <= {1'b0, 1'b0, i_selector, i_pred_en, 7'h00, i_cnt_en,
                         i_cnt_en ? i_count : 7'h00, 8'h00};
         port.pay_w3                   <= i_pred_mask & width_mask;
      end else if (port.req_ready) begin
         port.req_valid <= 1'b0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_wb_valid  <= 1'b0;
         o_wb_thread <= '0;
         o_wb_data   <= 32'h0000_0000;
      end else begin
         o_wb_valid  <= port.wb_valid;
         o_wb_thread <= port.wb_thread;
         o_wb_data   <= port.wb_dword0;
      end
   end
endmodule : tbmu_thread

// >>> testbench/tbmu_properties.sv
// Concurrent checks on the barrier message port between thread sender and gateway.
`timescale 1ns/1ps
module tbmu_properties
   import tbmu_pkg::*;
(
   input wire logic                  i_clk,
   input wire logic                  i_rst,
   input wire logic                  req_valid,
   input wire logic                  req_ready,
   input wire logic [2:0]            gateway_subfunction_code,
   input wire logic [31:0]           pay_w2,
   input wire logic                  wb_valid,
   input wire logic [TBMU_TID_W-1:0] wb_thread,
   input wire logic [31:0]           wb_dword0,
   input wire logic                  wb_is_sum
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   property p_ack_fmt;
      wb_valid && !wb_is_sum |-> wb_dword0[31:20] == 12'h0 && wb_dword0[15:3] == 13'h0
         && wb_dword0[2:0] == TBMU_ERR_OK;
   endproperty
   a_ack_fmt: assert property (p_ack_fmt) else $error("ack dword malformed");
   property p_sum_bound;
      wb_valid && wb_is_sum |-> wb_dword0[15:0] <= 16'h0200;
   endproperty
   a_sum_bound: assert property (p_sum_bound) else $error("sum out of range");
   property p_rst_idle;
      $past(i_rst) |-> req_ready && !wb_valid;
   endproperty
   a_rst_idle: assert property (p_rst_idle) else $error("not idle after reset");
   property p_order;
      wb_valid ##1 wb_valid |-> wb_thread > $past(wb_thread);
   endproperty
   a_order: assert property (p_order) else $error("writebacks out of order");
   property p_release_len;
      $fell(req_ready) |-> ##[1:18] req_ready;
   endproperty
   a_release_len: assert property (p_release_len) else $error("release too long");
   property p_release_cause;
      $fell(req_ready) |-> $past(req_valid) && $past(gateway_subfunction_code) == TBMU_SUBFN_BARRIER;
   endproperty
   a_release_cause: assert property (p_release_cause) else $error("release without barrier");
   property p_wb_in_release;
      wb_valid |-> !$past(req_ready);
   endproperty
   a_wb_in_release: assert property (p_wb_in_release) else $error("writeback outside release");
   property p_sum_kind;
      wb_valid && $past(req_ready, 2) |-> wb_is_sum == $past(pay_w2[TBMU_PRED_EN_BIT], 2);
   endproperty
   a_sum_kind: assert property (p_sum_kind) else $error("writeback kind wrong");
   property p_sel_range;
      req_valid |-> !pay_w2[TBMU_SEL_HI];
   endproperty
   a_sel_range: assert property (p_sel_range) else $error("selector above range");
   c_ack: cover property (wb_valid && !wb_is_sum);
   c_sum: cover property (wb_valid && wb_is_sum);
   c_stall: cover property (req_valid && !req_ready);
endmodule : tbmu_properties

// >>> testbench/tb.sv
// Self-checking bench joining the thread sender to the barrier gateway.
`timescale 1ns/1ps
module tb;
   import tbmu_pkg::*;
   typedef struct packed {
      logic [3:0] thr; logic [5:0] sel; logic pe; logic [1:0] sw; logic [31:0] mask;
      logic ce; logic [6:0] cnt; logic ack; logic [15:0] wbm; logic [31:0] data;
   } tbmu_row_s;
   localparam logic [31:0] ACKW = {12'h0, TBMU_SFID_DEFAULT, 13'h0, TBMU_ERR_OK};
   localparam tbmu_row_s rows [9] = '{
      '{1, 1, 0, 0, 0, 1, 2, 1, 16'h0, 0}, '{2, 1, 0, 0, '1, 0, 7'h7f, 1, 16'h6, ACKW},
      '{3, 1, 0, 0, 0, 0, 0, 0, 16'h0, 0}, '{4, 1, 0, 0, 0, 0, 0, 1, 16'h10, ACKW},
      '{5, 63, 0, 0, 0, 1, 1, 1, 16'h20, ACKW}, '{6, 2, 0, 0, 0, 1, 2, 1, 16'h0, 0},
      '{7, 2, 0, 0, 0, 0, 0, 1, 16'hc0, ACKW}, '{8, 2, 1, 0, 32'hffffff0f, 0, 0, 0, 16'h0, 0},
      '{9, 2, 1, 1, 32'hffff00ff, 0, 0, 0, 16'h300, 32'hc}};
   logic        i_clk, i_rst, i_send, i_pred_en, i_cnt_en, i_ack, o_sent, o_wb_valid, o_busy;
   logic [3:0]  i_thread, o_wb_thread;
   logic [5:0]  i_selector, o_last_done;
   logic [1:0]  i_simd_width;
   logic [31:0] i_pred_mask, o_wb_data;
   logic [6:0]  i_count;
   logic [3:0]  wq_t [$];
   logic [31:0] wq_d [$];
   int          mismatches = 0;
   int          checked = 0;
   tbmu_if bus ();
   tbmu_gateway tbmu_gateway_inst (.i_clk(i_clk), .i_rst(i_rst), .i_sfid(TBMU_SFID_DEFAULT),
      .o_busy(o_busy), .o_last_done(o_last_done), .port(bus));
   tbmu_thread tbmu_thread_inst (.i_clk(i_clk), .i_rst(i_rst), .i_send(i_send),
      .i_thread(i_thread), .i_selector(i_selector), .i_pred_en(i_pred_en),
      .i_simd_width(i_simd_width), .i_pred_mask(i_pred_mask), .i_cnt_en(i_cnt_en),
      .i_count(i_count), .i_ack(i_ack), .o_sent(o_sent), .o_wb_valid(o_wb_valid),
      .o_wb_thread(o_wb_thread), .o_wb_data(o_wb_data), .port(bus));
   tbmu_properties tbmu_properties_inst (.i_clk(i_clk), .i_rst(i_rst),
      .req_valid(bus.req_valid), .req_ready(bus.req_ready),
      .gateway_subfunction_code(bus.gateway_subfunction_code), .pay_w2(bus.pay_w2),
      .wb_valid(bus.wb_valid), .wb_thread(bus.wb_thread), .wb_dword0(bus.wb_dword0),
      .wb_is_sum(bus.wb_is_sum));
   task automatic end_of_test();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // The sender loads on every edge that sees the strobe and no stall, so the strobe
   // stands for exactly one loading edge; holding it longer would send the message twice.
   task automatic send(input tbmu_row_s r);
      int n;
      @(negedge i_clk);
      {i_thread, i_selector, i_pred_en, i_simd_width} = {r.thr, r.sel, r.pe, r.sw};
      {i_pred_mask, i_cnt_en, i_count, i_ack} = {r.mask, r.ce, r.cnt, r.ack};
      i_send = 1'b1;
      n = 0;
      while (bus.req_valid === 1'b1 && bus.req_ready !== 1'b1 && n < 40) begin
         @(negedge i_clk);
         n++;
      end
      @(negedge i_clk);
      i_send = 1'b0;
      #1;
      while (o_sent !== 1'b1 && n < 40) begin
         @(negedge i_clk);
         #1;
         n++;
      end
      chk({31'h0, o_sent}, 32'h1);
   endtask : send
   always @(posedge i_clk) if (o_wb_valid === 1'b1) begin
      wq_t.push_back(o_wb_thread);
      wq_d.push_back(o_wb_data);
   end
   initial begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end
   initial begin
      repeat (5000) @(posedge i_clk);
      mismatches++;
      end_of_test();
   end
   initial begin
      {i_rst, i_send, i_thread, i_selector, i_pred_en, i_simd_width} = '0;
      {i_pred_mask, i_cnt_en, i_count, i_ack} = '0;
      i_rst = 1'b1;
      repeat (20) @(negedge i_clk);
      i_rst = 1'b0;
      foreach (rows[i]) begin
         wq_t.delete();
         wq_d.delete();
         send(rows[i]);
         // Release of all sixteen threads fits well inside this span.
         repeat (24) @(negedge i_clk);
         chk(wq_t.size(), $countones(rows[i].wbm));
         foreach (wq_t[k]) begin
            chk(rows[i].wbm[wq_t[k]] && (k == 0 || wq_t[k] > wq_t[k-1]), 1);
            chk(wq_d[k], rows[i].data);
         end
         if (rows[i].wbm != 16'h0) chk(o_last_done, rows[i].sel);
      end
      wq_t.delete();
      send('{12, 4, 0, 0, 0, 1, 2, 1, 16'h0, 0});
      send('{13, 4, 0, 0, 0, 0, 0, 1, 16'h0, 0});
      send('{14, 4, 0, 0, 0, 1, 1, 1, 16'h0, 0});
      repeat (24) @(negedge i_clk);
      chk(wq_t.size(), 3);
      send('{10, 3, 0, 0, 0, 1, 2, 1, 16'h0, 0});
      // Let the arrival land first, so that reset has a count and a limit to clear.
      @(negedge i_clk);
      i_rst = 1'b1;
      repeat (2) @(negedge i_clk);
      chk({o_busy, bus.req_ready, bus.wb_valid}, 3'h2);
      i_rst = 1'b0;
      wq_t.delete();
      send('{11, 3, 0, 0, 0, 0, 0, 1, 16'h0, 0});
      repeat (24) @(negedge i_clk);
      chk(wq_t.size(), 0);
      end_of_test();
   end
endmodule : tb
